// *** cm_defs.svh ***
`ifndef CM_DEFS_SVH
`define CM_DEFS_SVH

// Register byte offsets within the block's window
`define CM_OFS_CSR       12'h000
`define CM_OFS_BEEP      12'h004

// Reset values
`define CM_CSR_RESET     8'h00
`define CM_BEEP_RESET    2'h0

// Time-base periods in oscillator clock cycles
`define CM_TB_PERIOD0    18'd16000
`define CM_TB_PERIOD1    18'd32000
`define CM_TB_PERIOD2    18'd80000
`define CM_TB_PERIOD3    18'd200000

// Tone divider taps: bit k of the free counter has period 2^(k+1)
`define CM_TONE_TAP_HI   11
`define CM_TONE_TAP_MID  12
`define CM_TONE_TAP_LO   13

`endif

// *** cm_pkg.sv ***
package cm_pkg;

   typedef enum logic [1:0] {
      CM_RUN,
      CM_OSC_SLEEP,
      CM_DEEP_STOP
   } cm_mode_t;

   typedef enum logic [1:0] {
      CM_WR_NONE,
      CM_WR_CSR,
      CM_WR_BEEP
   } cm_wr_t;

   typedef struct packed {
      logic       clock_out_enable;
      logic [1:0] slow_divisor_sel;
      logic       slow_select;
      logic [1:0] timebase_sel;
      logic       timebase_irq_enable;
      logic       timebase_flag;
   } cm_csr_t;

   typedef struct packed {
      cm_csr_t    csr;
      logic [1:0] tone_sel;
      cm_mode_t   mode;
      logic [17:0] tb_cnt;
      logic [1:0] tb_cur;
      logic [3:0] pre_cnt;
      logic       cpu_en;
      logic       clk_out;
      logic       clk_oe;
      logic [13:0] tone_cnt;
      logic       tone;
      logic       tone_oe;
      logic       irq;
      cm_wr_t     wr;
      logic [31:0] hrdata;
      logic       hreadyout;
      logic       hresp;
   } cm_state_t;

endpackage : cm_pkg

// *** cm_clock_manager.sv ***
// Function
// - Slow select 0 runs CPU clock at oscillator rate, 1 uses prescaler divisor
// - Prescaler field codes 00..11 divide oscillator clock by 2, 4, 8, 16
// - Bit 7 enables clock-out pin driving slow CPU clock or half oscillator rate, else pin left free
// - Clock-out stops toggling during oscillator-running sleep
// - Time-base field selects 16000, 32000, 80000 or 200000 oscillator cycles
// - New time-base selection takes effect only from the next period
// - Time-base flag in bit 0 sets whenever the period elapses
// - Reading the control/status register clears the flag, nothing else does
// - Interrupt request is flag AND enable; global masking left to CPU
// - Halt with interrupt enable set enters oscillator sleep, else deep stop
// - Time-base interrupt wakes from idle and sleep, never from deep stop
// - Deep stop freezes counter and registers until an allowed wake
// - Oscillator sleep keeps the counter running, registers frozen
// - Core idle leaves the block running exactly as in run mode
// - Tone field: off, ~2 kHz, ~1 kHz, ~500 Hz at 8 MHz, 50% duty
// - Tone keeps running in oscillator sleep when enabled
// - Both registers read all zeros after reset
// - Prescaler, clock-out and time-base work independently and together
`timescale 1ns/1ps
`include "cm_defs.svh"

module cm_clock_manager
   import cm_pkg::*;
(
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_n_i,
   // AHB-Lite slave
   input  wire logic        hsel_i,
   input  wire logic [31:0] haddr_i,
   input  wire logic [1:0]  htrans_i,
   input  wire logic        hwrite_i,
   input  wire logic [2:0]  hsize_i,
   input  wire logic [31:0] hwdata_i,
   input  wire logic        hready_i,
   output logic      [31:0] hrdata_o,
   output logic             hreadyout_o,
   output logic             hresp_o,
   // CPU power control
   input  wire logic        halt_exec_i,
   input  wire logic        wake_i,
   output cm_mode_t         mode_o,
   output logic             cpu_clk_en_o,
   output logic             timebase_irq_o,
   // Pins
   output logic             clock_out_pin_o,
   output logic             clock_out_oe_o,
   output logic             tone_out_pin_o,
   output logic             tone_out_oe_o
);

   cm_state_t s_reg;
   cm_state_t s_next;

   logic [17:0] period;
   logic        tb_end;
   logic        tb_run;
   logic        access;
   logic        rd_csr;
   logic [11:0] ofs;
   logic [3:0]  div_mask;
   logic        tone_bit;

   function automatic logic [17:0] tb_period(input logic [1:0] sel);
      case (sel)
         2'h0:    tb_period = `CM_TB_PERIOD0;
         2'h1:    tb_period = `CM_TB_PERIOD1;
         2'h2:    tb_period = `CM_TB_PERIOD2;
         default: tb_period = `CM_TB_PERIOD3;
      endcase
   endfunction : tb_period

   always_comb
   begin
      s_next   = s_reg;
      ofs      = haddr_i[11:0];
      access   = hsel_i && htrans_i[1] && hready_i;
      // Accesses only act while the core runs; sleep modes freeze registers
      rd_csr   = access && !hwrite_i && (ofs == `CM_OFS_CSR)
                 && (s_reg.mode == CM_RUN);
      tb_run   = (s_reg.mode != CM_DEEP_STOP);
      period   = tb_period(s_reg.tb_cur);
      tb_end   = tb_run && (s_reg.tb_cnt == period - 18'd1);

      // Time base: finishes current period at its old length
      if (tb_run)
      begin
         if (tb_end)
         begin
            s_next.tb_cnt = 18'h00000;
            s_next.tb_cur = s_reg.csr.timebase_sel;
         end
         else
         begin
            s_next.tb_cnt = s_reg.tb_cnt + 18'd1;
         end
      end

      // Data phase write
      case (s_reg.wr)
         CM_WR_CSR:
         begin
            s_next.csr.clock_out_enable    = hwdata_i[7];
            s_next.csr.slow_divisor_sel    = hwdata_i[6:5];
            s_next.csr.slow_select         = hwdata_i[4];
            s_next.csr.timebase_sel        = hwdata_i[3:2];
            s_next.csr.timebase_irq_enable = hwdata_i[1];
         end
         CM_WR_BEEP:
            s_next.tone_sel = hwdata_i[1:0];
         default:
            s_next.tone_sel = s_reg.tone_sel;
      endcase

      // Flag: set wins over the read clear
      if (rd_csr)
         s_next.csr.timebase_flag = 1'b0;
      if (tb_end)
         s_next.csr.timebase_flag = 1'b1;

      // Address phase
      s_next.wr     = CM_WR_NONE;
      s_next.hrdata = 32'h00000000;
      if (access && (s_reg.mode == CM_RUN))
      begin
         if (hwrite_i)
         begin
            if (ofs == `CM_OFS_CSR)
               s_next.wr = CM_WR_CSR;
            else if (ofs == `CM_OFS_BEEP)
               s_next.wr = CM_WR_BEEP;
            else
               s_next.wr = CM_WR_NONE;
         end
         else if (ofs == `CM_OFS_CSR)
            s_next.hrdata = {24'h000000, s_reg.csr};
         else if (ofs == `CM_OFS_BEEP)
            s_next.hrdata = {30'h00000000, s_reg.tone_sel};
         else
            s_next.hrdata = 32'h00000000;
      end
      s_next.hreadyout = 1'b1;
      s_next.hresp     = 1'b0;

      // Power mode sequencing
      // Halt is honoured only in run mode; a missed pulse is not queued
      case (s_reg.mode)
         CM_RUN:
            if (halt_exec_i)
               s_next.mode = s_reg.csr.timebase_irq_enable
                             ? CM_OSC_SLEEP : CM_DEEP_STOP;
         CM_OSC_SLEEP:
            if (s_reg.irq || tb_end || wake_i)
               s_next.mode = CM_RUN;
         CM_DEEP_STOP:
            if (wake_i)
               s_next.mode = CM_RUN;
         default:
            s_next.mode = CM_RUN;
      endcase

      // CPU prescaler, independent of the time base
      // Prescaler freezes together with the time base in deep stop
      div_mask = 4'h0;
      if (tb_run)
         s_next.pre_cnt = s_reg.pre_cnt + 4'h1;
      case (s_reg.csr.slow_divisor_sel)
         2'h0:    div_mask = 4'h1;
         2'h1:    div_mask = 4'h3;
         2'h2:    div_mask = 4'h7;
         default: div_mask = 4'hf;
      endcase
      if (s_reg.csr.slow_select)
         s_next.cpu_en = tb_run
                         && ((s_reg.pre_cnt & div_mask) == div_mask);
      else
         s_next.cpu_en = tb_run;

      // Clock-out pin
      // Full-rate clock-out is half the oscillator rate: the pin is a flop
      s_next.clk_oe = s_reg.csr.clock_out_enable;
      if (!s_reg.csr.clock_out_enable || (s_reg.mode != CM_RUN))
         s_next.clk_out = 1'b0;
      else if (s_reg.csr.slow_select)
         s_next.clk_out = s_reg.pre_cnt[s_reg.csr.slow_divisor_sel];
      else
         s_next.clk_out = !s_reg.clk_out;

      // Beeper from power-of-two taps, runs in oscillator sleep
      tone_bit = 1'b0;
      if (tb_run)
         s_next.tone_cnt = s_reg.tone_cnt + 14'h0001;
      case (s_reg.tone_sel)
         2'h1:    tone_bit = s_reg.tone_cnt[`CM_TONE_TAP_HI];
         2'h2:    tone_bit = s_reg.tone_cnt[`CM_TONE_TAP_MID];
         2'h3:    tone_bit = s_reg.tone_cnt[`CM_TONE_TAP_LO];
         default: tone_bit = 1'b0;
      endcase
      s_next.tone    = tone_bit;
      s_next.tone_oe = (s_reg.tone_sel != 2'h0);

      // Built from next state so the request lines up with the flag
      s_next.irq = s_next.csr.timebase_flag
                   && s_next.csr.timebase_irq_enable;
   end

   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         s_reg           <= '0;
         s_reg.csr       <= `CM_CSR_RESET;
         s_reg.tone_sel  <= `CM_BEEP_RESET;
         s_reg.mode      <= CM_RUN;
         s_reg.wr        <= CM_WR_NONE;
         s_reg.hreadyout <= 1'b1;
      end
      else
      begin
         s_reg <= s_next;
      end
   end

   assign hrdata_o        = s_reg.hrdata;
   assign hreadyout_o     = s_reg.hreadyout;
   assign hresp_o         = s_reg.hresp;
   assign mode_o          = s_reg.mode;
   assign cpu_clk_en_o    = s_reg.cpu_en;
   assign timebase_irq_o  = s_reg.irq;
   assign clock_out_pin_o = s_reg.clk_out;
   assign clock_out_oe_o  = s_reg.clk_oe;
   assign tone_out_pin_o  = s_reg.tone;
   assign tone_out_oe_o   = s_reg.tone_oe;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   a_tb_flag_set: assert property (tb_end |=> s_reg.csr.timebase_flag)
      else $error("time-base flag not set at period end");
   a_tb_restart: assert property (tb_end |=> s_reg.tb_cnt == 18'h00000
      && s_reg.tb_cur == $past(s_reg.csr.timebase_sel))
      else $error("time-base period did not restart");
   a_read_clear: assert property (rd_csr && !tb_end
      |=> !s_reg.csr.timebase_flag)
      else $error("status read did not clear flag");
   a_irq_follows: assert property (timebase_irq_o == (s_reg.csr.timebase_flag
      && s_reg.csr.timebase_irq_enable))
      else $error("interrupt request does not match flag and enable");
   a_halt_sleep: assert property (s_reg.mode == CM_RUN && halt_exec_i
      && s_reg.csr.timebase_irq_enable |=> mode_o == CM_OSC_SLEEP)
      else $error("halt with enable did not enter oscillator sleep");
   a_halt_stop: assert property (s_reg.mode == CM_RUN && halt_exec_i
      && !s_reg.csr.timebase_irq_enable |=> mode_o == CM_DEEP_STOP)
      else $error("halt without enable did not enter deep stop");
   a_stop_frozen: assert property (s_reg.mode == CM_DEEP_STOP && !wake_i
      |=> $stable(s_reg.tb_cnt) && $stable(s_reg.csr)
      && mode_o == CM_DEEP_STOP)
      else $error("deep stop did not hold state");
   a_sleep_counts: assert property (s_reg.mode == CM_OSC_SLEEP && !tb_end
      |=> s_reg.tb_cnt == $past(s_reg.tb_cnt) + 18'd1)
      else $error("counter stalled in oscillator sleep");
   a_clkout_quiet: assert property (s_reg.mode != CM_RUN
      |=> !clock_out_pin_o)
      else $error("clock-out toggled while asleep");
   a_cpu_full: assert property (!s_reg.csr.slow_select && tb_run
      |=> cpu_clk_en_o)
      else $error("CPU clock not at full rate");
   a_tone_off: assert property (s_reg.tone_sel == 2'h0
      |=> !tone_out_pin_o && !tone_out_oe_o)
      else $error("tone active while off");

   // Register bus answers
   a_bus_okay: assert property (!hresp_o && hreadyout_o)
      // bus always answers OKAY with no wait state
      else $error("bus response not OKAY or not ready");
   a_rd_idle: assert property (!(access && !hwrite_i && s_reg.mode == CM_RUN)
      |=> hrdata_o == 32'h00000000)
      else $error("read data not zero outside a read");
   a_no_access: assert property (s_reg.mode != CM_RUN
      |=> hrdata_o == 32'h00000000 && s_reg.wr == CM_WR_NONE)
      else $error("bus access taken while asleep");
   a_wr_csr: assert property (access && hwrite_i && ofs == `CM_OFS_CSR
      && s_reg.mode == CM_RUN |=> s_reg.wr == CM_WR_CSR)
      else $error("status write not decoded");
   a_wr_beep: assert property (access && hwrite_i && ofs == `CM_OFS_BEEP
      && s_reg.mode == CM_RUN |=> s_reg.wr == CM_WR_BEEP)
      else $error("beep write not decoded");
   a_rd_csr: assert property (rd_csr
      |=> hrdata_o == {24'h000000, $past(s_reg.csr)})
      else $error("status read data wrong");
   a_rd_beep: assert property (access && !hwrite_i && ofs == `CM_OFS_BEEP
      && s_reg.mode == CM_RUN |=> hrdata_o[1:0] == $past(s_reg.tone_sel))
      else $error("beep read data wrong");
   a_csr_write: assert property (s_reg.wr == CM_WR_CSR
      |=> s_reg.csr[7:1] == $past(hwdata_i[7:1]))
      else $error("status write not stored");
   a_beep_write: assert property (s_reg.wr == CM_WR_BEEP
      |=> s_reg.tone_sel == $past(hwdata_i[1:0]))
      else $error("beep write not stored");
   a_hrdata_high: assert property (hrdata_o[31:8] == 24'h000000)
      // registers are at most eight bits wide
      else $error("read data upper bits not zero");

   // Time base
   a_tb_count: assert property (tb_run && !tb_end
      |=> s_reg.tb_cnt == $past(s_reg.tb_cnt) + 18'd1)
      else $error("time-base counter did not advance");
   a_tb_bound: assert property (s_reg.tb_cnt < period)
      else $error("time-base counter beyond its period");
   a_tb_keep: assert property (tb_run && !tb_end
      |=> $stable(s_reg.tb_cur))
      else $error("period length changed mid-period");
   a_flag_hold: assert property (!tb_end && !rd_csr
      |=> s_reg.csr.timebase_flag == $past(s_reg.csr.timebase_flag))
      else $error("time-base flag changed without cause");
   a_flag_cause: assert property ($rose(s_reg.csr.timebase_flag)
      |-> $past(tb_end))
      else $error("time-base flag set without period end");

   // Power modes
   a_sleep_wake: assert property (s_reg.mode == CM_OSC_SLEEP
      && (s_reg.irq || wake_i) |=> mode_o == CM_RUN)
      else $error("oscillator sleep did not wake");
   a_sleep_stays: assert property (s_reg.mode == CM_OSC_SLEEP && !s_reg.irq
      && !tb_end && !wake_i |=> mode_o == CM_OSC_SLEEP)
      else $error("oscillator sleep left without cause");
   a_deep_wake: assert property (s_reg.mode == CM_DEEP_STOP && wake_i
      |=> mode_o == CM_RUN)
      else $error("deep stop did not wake");
   a_mode_legal: assert property (mode_o inside
      {CM_RUN, CM_OSC_SLEEP, CM_DEEP_STOP})
      else $error("power mode out of range");
   a_stop_cpu: assert property (s_reg.mode == CM_DEEP_STOP
      |=> !cpu_clk_en_o)
      else $error("CPU clock running in deep stop");
   a_pre_frozen: assert property (s_reg.mode == CM_DEEP_STOP
      |=> $stable(s_reg.pre_cnt))
      else $error("prescaler ran in deep stop");
   a_tone_frozen: assert property (s_reg.mode == CM_DEEP_STOP
      |=> $stable(s_reg.tone_cnt))
      else $error("tone counter ran in deep stop");

   // Clocks and pins
   a_slow_pulse: assert property (s_reg.csr.slow_select
      && $past(s_reg.csr.slow_select) && cpu_clk_en_o
      |=> !cpu_clk_en_o)
      else $error("slow CPU clock enable wider than one cycle");
   a_full_clkout: assert property (s_reg.mode == CM_RUN
      && s_reg.csr.clock_out_enable && !s_reg.csr.slow_select
      |=> clock_out_pin_o != $past(clock_out_pin_o))
      else $error("full-rate clock-out did not toggle");
   a_clkout_off: assert property (!s_reg.csr.clock_out_enable
      |=> !clock_out_pin_o)
      else $error("clock-out driven while disabled");
   a_clkout_oe: assert property (1'b1
      |=> clock_out_oe_o == $past(s_reg.csr.clock_out_enable))
      else $error("clock-out enable does not follow its bit");
   a_tone_oe: assert property (s_reg.tone_sel != 2'h0
      |=> tone_out_oe_o)
      else $error("tone pin not enabled");
   a_sleep_tone: assert property (s_reg.mode == CM_OSC_SLEEP
      |=> s_reg.tone_cnt == $past(s_reg.tone_cnt) + 14'h0001)
      else $error("tone stopped in oscillator sleep");

   c_enter_sleep: cover property (s_reg.mode == CM_RUN ##1
      s_reg.mode == CM_OSC_SLEEP);
   c_tb_wake: cover property (s_reg.mode == CM_OSC_SLEEP && tb_end);
   c_slow16: cover property (s_reg.csr.slow_select
      && s_reg.csr.slow_divisor_sel == 2'h3 && cpu_clk_en_o);
   c_tone_on: cover property (tone_out_oe_o && tone_out_pin_o);
   c_deep_wake: cover property (s_reg.mode == CM_DEEP_STOP && wake_i);

endmodule : cm_clock_manager

// *** tb_top.sv ***
`timescale 1ns/1ps

module tb_top
   import cm_pkg::*;
;
   localparam int LIMIT = 100000;
   logic        clk_i = 1'b0;
   logic        rst_n_i = 1'b0;
   logic        hsel_i = 1'b0;
   logic [31:0] haddr_i = 32'h0;
   logic [1:0]  htrans_i = 2'h0;
   logic        hwrite_i = 1'b0;
   logic [31:0] hwdata_i = 32'h0;
   logic        halt_exec_i = 1'b0;
   logic        wake_i = 1'b0;
   logic [31:0] hrdata_o;
   logic        hreadyout_o;
   logic        hresp_o;
   cm_mode_t    mode_o;
   logic        cpu_clk_en_o;
   logic        timebase_irq_o;
   logic        clock_out_pin_o;
   logic        clock_out_oe_o;
   logic        tone_out_pin_o;
   logic        tone_out_oe_o;
   int          failures = 0;
   int          num_checks = 0;
   int          cyc = 0;
   int          t0, n_en, n_co, n_tone;
   logic [31:0] rd;

   cm_clock_manager cm_clock_manager_inst (
      .clk_i(clk_i), .rst_n_i(rst_n_i), .hsel_i(hsel_i),
      .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
      .hsize_i(3'h2), .hwdata_i(hwdata_i), .hready_i(hreadyout_o),
      .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
      .halt_exec_i(halt_exec_i), .wake_i(wake_i), .mode_o(mode_o),
      .cpu_clk_en_o(cpu_clk_en_o), .timebase_irq_o(timebase_irq_o),
      .clock_out_pin_o(clock_out_pin_o), .clock_out_oe_o(clock_out_oe_o),
      .tone_out_pin_o(tone_out_pin_o), .tone_out_oe_o(tone_out_oe_o));

   always #4 clk_i = ~clk_i;

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : print_verdict

   // Hang guard
   always @(posedge clk_i)
   begin
      cyc <= cyc + 1;
      if (cyc >= LIMIT)
      begin
         failures = failures + 1;
         print_verdict();
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks = num_checks + 1;
      if (seen !== exp)
      begin
         failures = failures + 1;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic ahb(input logic wr, input logic [31:0] a,
                      input logic [31:0] d);
      hsel_i   <= 1'b1;
      haddr_i  <= a;
      htrans_i <= 2'h2;
      hwrite_i <= wr;
      @(posedge clk_i);
      while (hreadyout_o !== 1'b1) @(posedge clk_i);
      htrans_i <= 2'h0;
      hsel_i   <= 1'b0;
      hwdata_i <= d;
      @(posedge clk_i);
      while (hreadyout_o !== 1'b1) @(posedge clk_i);
      rd = hrdata_o;
   endtask : ahb

   // Counts enable pulses and pin toggles over n cycles
   task automatic watch(input int n);
      logic co, tn;
      n_en = 0;
      n_co = 0;
      n_tone = 0;
      co = clock_out_pin_o;
      tn = tone_out_pin_o;
      repeat (n)
      begin
         @(posedge clk_i);
         n_en = n_en + int'(cpu_clk_en_o === 1'b1);
         n_co = n_co + int'(clock_out_pin_o !== co);
         n_tone = n_tone + int'(tone_out_pin_o !== tn);
         co = clock_out_pin_o;
         tn = tone_out_pin_o;
      end
   endtask : watch

   task automatic wait_irq();
      while (timebase_irq_o !== 1'b1) @(posedge clk_i);
   endtask : wait_irq

   task automatic test_reset();
      ahb(1'b0, 32'h000, 32'h0);
      check(rd, 32'h0);
      ahb(1'b0, 32'h004, 32'h0);
      check(rd, 32'h0);
      ahb(1'b0, 32'h00c, 32'h0);
      check(rd, 32'h0);
      check(hresp_o, 1'b0);
      check(hreadyout_o, 1'b1);
   endtask : test_reset

   task automatic test_timebase();
      ahb(1'b1, 32'h000, 32'h03);
      ahb(1'b0, 32'h000, 32'h0);
      check(rd, 32'h02);
      wait_irq();
      t0 = cyc;
      ahb(1'b0, 32'h000, 32'h0);
      check(rd, 32'h03);
      repeat (2) @(posedge clk_i);
      check(timebase_irq_o, 1'b0);
      ahb(1'b1, 32'h000, 32'h06);
      wait_irq();
      check(cyc - t0, 16000);
      t0 = cyc;
      ahb(1'b0, 32'h000, 32'h0);
      check(rd, 32'h07);
      wait_irq();
      check(cyc - t0, 32000);
      ahb(1'b0, 32'h000, 32'h0);
   endtask : test_timebase

   task automatic test_slow();
      for (int cp = 0; cp < 4; cp++)
      begin
         ahb(1'b1, 32'h000, 32'h96 | (cp << 5));
         repeat (4) @(posedge clk_i);
         watch(64);
         check(n_en, 64 >> (cp + 1));
         check(n_co, 128 >> (cp + 1));
         check(clock_out_oe_o, 1'b1);
      end
      ahb(1'b1, 32'h000, 32'h86);
      repeat (4) @(posedge clk_i);
      watch(64);
      check(n_en, 64);
      check(n_co, 64);
   endtask : test_slow

   task automatic test_tone();
      for (int b = 1; b < 4; b++)
      begin
         ahb(1'b1, 32'h004, 32'(b));
         repeat (4) @(posedge clk_i);
         check(tone_out_oe_o, 1'b1);
         watch(8192);
         check(n_tone, 4 >> (b - 1));
      end
      ahb(1'b1, 32'h004, 32'h0);
      repeat (4) @(posedge clk_i);
      check(tone_out_oe_o, 1'b0);
   endtask : test_tone

   task automatic halt_then(input logic [7:0] csr, input cm_mode_t m);
      ahb(1'b1, 32'h000, 32'(csr));
      ahb(1'b0, 32'h000, 32'h0);
      halt_exec_i <= 1'b1;
      @(posedge clk_i);
      halt_exec_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      check(mode_o, m);
      watch(16);
      check(n_co, 0);
      check(mode_o, m);
      wake_i <= 1'b1;
      @(posedge clk_i);
      wake_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      check(mode_o, CM_RUN);
   endtask : halt_then

   initial
   begin
      repeat (3) @(posedge clk_i);
      rst_n_i <= 1'b1;
      @(posedge clk_i);
      test_reset();
      test_timebase();
      test_slow();
      test_tone();
      halt_then(8'h86, CM_OSC_SLEEP);
      halt_then(8'h84, CM_DEEP_STOP);
      check(cpu_clk_en_o, 1'b1);
      print_verdict();
   end
endmodule : tb_top
